// ---- verilog/cco_control.sv ----
// Comparator control register one with AXI4-Lite slave and output steering
`timescale 1ns/100ps
`include "cco_map.svh"
module cco_control (
   input wire logic aclk, // Bus clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic raw_compare_out, // Unfiltered analog result, async
   input wire logic filtered_compare_out, // Filter block output, async
   input wire logic timer_trigger, // External timer trigger level, async
   input wire logic mux_same_input, // Plus and minus mux select equal
   input wire logic pin_owned, // Pin mux gives pin to comparator
   output logic analog_power_on, // Comparator powered
   output logic dac_power_on, // DAC allowed to run in trigger mode
   output logic speed_power_sel, // High speed when high
   output logic sample_mode_sel, // Sampling mode select to filter
   output logic [2:0] filter_count, // Filter count for sampler bypass
   output logic module_compare_out, // Module output after polarity
   output logic pin_out, // Comparator pin output value
   output logic pin_oe, // Comparator pin output enable
   output logic status_compare_out // Output status bit
);
   // ==========================================================
   // Input synchronisers
   // Two flops per async input; only the second is read
   logic [2:0] sync1_reg, sync1_next;
   logic [2:0] sync2_reg, sync2_next;
   logic trig_prev_reg, trig_prev_next;

   always_comb begin
      sync1_next = {timer_trigger, filtered_compare_out, raw_compare_out};
      sync2_next = sync1_reg;
      trig_prev_next = sync2_reg[2];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         trig_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         trig_prev_reg <= trig_prev_next;
      end
   end

   // Rising edge only, so a long trigger gives one compare
   logic trig_pulse;
   assign trig_pulse = sync2_reg[2] & ~trig_prev_reg;

   // ==========================================================
   // AXI4-Lite write channel
   cco_pkg::cco_ctrl_type ctrl_reg, ctrl_next;
   logic aw_held_reg, aw_held_next;
   logic w_held_reg, w_held_next;
   logic [3:0] awaddr_reg, awaddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic wstrb0_reg, wstrb0_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;

   // ==========================================================
   // Address decode
   // Only address bits 3:2 decode; the low bits are ignored
   logic wr_is_ctrl;
   logic wr_is_stat;
   logic rd_is_ctrl;
   logic rd_is_stat;
   assign wr_is_ctrl = awaddr_reg[3:2] == 2'(`CCO_CTRL_IDX);
   assign wr_is_stat = awaddr_reg[3:2] == 2'(`CCO_STAT_ADDR >> 2);
   assign rd_is_ctrl = s_axi_araddr[3:2] == 2'(`CCO_CTRL_IDX);
   assign rd_is_stat = s_axi_araddr[3:2] == 2'(`CCO_STAT_ADDR >> 2);

   // ==========================================================
   // Write handshake and register update
   // Either half may come first; the response waits for both
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb0_next = wstrb0_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      ctrl_next = ctrl_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_next = 1'b1;
         wdata_next = s_axi_wdata[7:0];
         wstrb0_next = s_axi_wstrb[0];
      end
      if (aw_held_reg && w_held_reg && !bvalid_reg) begin
         aw_held_next = 1'b0;
         w_held_next = 1'b0;
         bvalid_next = 1'b1;
         if (wr_is_ctrl) begin
            bresp_next = `CCO_RESP_OKAY;
            if (wstrb0_reg) begin
               ctrl_next = cco_pkg::cco_ctrl_type'(wdata_reg);
            end
         end else if (wr_is_stat) begin
            // Status is read only; the write is answered and dropped
            bresp_next = `CCO_RESP_OKAY;
         end else begin
            bresp_next = `CCO_RESP_SLVERR;
         end
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CCO_CTRL_RESET;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 4'h0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'b00;
      end else begin
         ctrl_reg <= ctrl_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb0_reg <= wstrb0_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
      end
   end

   // Ready drops while a half is held, so writes never overlap
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ==========================================================
   // AXI4-Lite read channel
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = `CCO_RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (rd_is_ctrl) begin
            rdata_next = {24'h00_0000, ctrl_reg};
         end else if (rd_is_stat) begin
            rdata_next = {31'h0000_0000, status_compare_out};
         end else begin
            rresp_next = `CCO_RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= 2'b00;
      end else begin
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   // One read at a time: no address taken while data waits
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ==========================================================
   // Trigger mode sequencer
   cco_pkg::cco_state_type state_reg, state_next;
   logic enabled;
   // Equal mux inputs count as disabled
   assign enabled = ctrl_reg.module_enable & ~mux_same_input;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         cco_pkg::CCO_OFF: begin
            if (enabled && ctrl_reg.triggered_compare_on) begin
               state_next = cco_pkg::CCO_STANDBY;
            end else if (enabled) begin
               state_next = cco_pkg::CCO_ACTIVE;
            end
         end
         cco_pkg::CCO_STANDBY: begin
            if (!enabled) begin
               state_next = cco_pkg::CCO_OFF;
            end else if (!ctrl_reg.triggered_compare_on) begin
               state_next = cco_pkg::CCO_ACTIVE;
            end else if (trig_pulse) begin
               state_next = cco_pkg::CCO_COMPARE;
            end
         end
         cco_pkg::CCO_COMPARE: begin
            state_next = enabled ? cco_pkg::CCO_STANDBY : cco_pkg::CCO_OFF;
         end
         cco_pkg::CCO_ACTIVE: begin
            if (!enabled) begin
               state_next = cco_pkg::CCO_OFF;
            end else if (ctrl_reg.triggered_compare_on) begin
               state_next = cco_pkg::CCO_STANDBY;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= cco_pkg::CCO_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Output path
   logic cmp_out_reg, cmp_out_next;
   logic selected;
   logic running;

   // Comparator runs only while enabled; a set trigger bit means standby outside the one compare cycle
   always_comb begin
      running = 1'b0;
      if (enabled && state_reg == cco_pkg::CCO_COMPARE) begin
         running = 1'b1;
      end else if (enabled && state_reg == cco_pkg::CCO_ACTIVE) begin
         running = ~ctrl_reg.triggered_compare_on;
      end
   end

   // Output holds its last value while in standby
   always_comb begin
      selected = ctrl_reg.output_sel ? sync2_reg[0] : sync2_reg[1];
      cmp_out_next = cmp_out_reg;
      if (!enabled) begin
         cmp_out_next = ctrl_reg.polarity_flip;
      end else if (running) begin
         cmp_out_next = selected ^ ctrl_reg.polarity_flip;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_out_reg <= 1'b0;
      end else begin
         cmp_out_reg <= cmp_out_next;
      end
   end

   assign module_compare_out = cmp_out_reg;
   assign status_compare_out = cmp_out_reg;

   // ==========================================================
   // Pin drive
   // Pin value always follows the module output; enable gates it
   assign pin_out = cmp_out_reg;
   assign pin_oe = pin_owned & ctrl_reg.output_pin_drive_on;

   // ==========================================================
   // Power and mode outputs
   // Sample bit goes to the filter; window bit is stored only
   assign analog_power_on = running;
   assign dac_power_on = running & ctrl_reg.triggered_compare_on;
   assign speed_power_sel = ctrl_reg.speed_power_sel;
   assign sample_mode_sel = ctrl_reg.sample_mode_sel;
   assign filter_count = 3'h1;
endmodule : cco_control

// ---- common/cco_map.svh ----
// Register offsets, field positions, reset values and rule overview for the control register
// Overview of operation
// - Trigger bit set configures comparator and DAC triggered
// - Standby until external timer trigger arrives
// - Each timer trigger produces one compare
// - Power bit selects low or high speed
// - Invert bit sets comparator output polarity
// - Polarity reaches pin and status when pin disabled (code: only when the module is disabled)
// - Output select picks filtered or raw output
// - Pin enable drives module output when owned
// - Pin enable ignored when pin not owned
// - Module enable off means comparator powered down
// - Same mux input both ports disables comparator
// - Disabled module reads invert bit as status
// - Bypassed filter with count one just samples
`ifndef CCO_MAP_SVH
`define CCO_MAP_SVH
`define CCO_CTRL_IDX 4'h1
`define CCO_CTRL_ADDR 4'h4
`define CCO_STAT_ADDR 4'h8
`define CCO_CTRL_RESET 8'h00
`define CCO_BIT_SAMPLE 7
`define CCO_BIT_WINDOW 6
`define CCO_BIT_TRIG 5
`define CCO_BIT_SPEED 4
`define CCO_BIT_FLIP 3
`define CCO_BIT_OSEL 2
`define CCO_BIT_PIN 1
`define CCO_BIT_EN 0
`define CCO_RESP_OKAY 2'b00
`define CCO_RESP_SLVERR 2'b10
`endif

// ---- common/cco_pkg.sv ----
// Types for the comparator control register block
package cco_pkg;
   typedef struct packed {
      logic sample_mode_sel;
      logic window_mode_sel;
      logic triggered_compare_on;
      logic speed_power_sel;
      logic polarity_flip;
      logic output_sel;
      logic output_pin_drive_on;
      logic module_enable;
   } cco_ctrl_type;

   typedef enum logic [1:0] {
      CCO_OFF = 2'b00,
      CCO_STANDBY = 2'b01,
      CCO_COMPARE = 2'b11,
      CCO_ACTIVE = 2'b10
   } cco_state_type;
endpackage : cco_pkg

// ---- testbench/cco_control_sva.sv ----
// Checker for the comparator control block
`timescale 1ns/100ps
module cco_control_sva (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset
   input wire logic s_axi_arready, // Read ready
   input wire logic s_axi_bvalid, // Resp valid
   input wire logic s_axi_bready, // Resp ready
   input wire logic [1:0] s_axi_bresp, // Resp code
   input wire logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read taken
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic mux_same_input, // Same mux
   input wire logic pin_owned, // Pin owned
   input wire logic analog_power_on, // Running
   input wire logic dac_power_on, // DAC on
   input wire logic [2:0] filter_count, // Count
   input wire logic module_compare_out, // Output
   input wire logic pin_out, // Pin value
   input wire logic pin_oe, // Pin enable
   input wire logic status_compare_out // Status
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PIN_OWNED: assert property (!pin_owned |-> !pin_oe)
      else $error("pin driven while not owned");
   AST_PIN_VALUE: assert property (pin_oe |-> pin_out == module_compare_out)
      else $error("pin value differs from module output");
   AST_DAC_RUN: assert property (dac_power_on |-> analog_power_on)
      else $error("dac on while comparator off");
   AST_MUX_OFF: assert property (mux_same_input |-> !analog_power_on)
      else $error("comparator runs with equal mux inputs");
   AST_STATUS: assert property (status_compare_out == module_compare_out)
      else $error("status differs from module output");
   AST_SAMPLER: assert property (filter_count == 3'h1)
      else $error("filter count not one");
   AST_COMPARE_ONE: assert property ($rose(dac_power_on) |=> !dac_power_on)
      else $error("triggered compare longer than one cycle");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   cover property ($rose(dac_power_on));
   cover property (pin_oe);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule : cco_control_sva
bind cco_control cco_control_sva chk (.*);

// ---- testbench/cco_far_model.sv ----
// Far side model: comparator results and timer trigger
`timescale 1ns/100ps
module cco_far_model (
   input wire logic aclk, // Clock
   input wire logic raw_lvl, // Raw result wanted
   input wire logic filt_lvl, // Filtered result wanted
   input wire logic fire, // One trigger wanted
   output logic raw_compare_out, // Raw result
   output logic filtered_compare_out, // Filtered result
   output logic timer_trigger // Trigger level
);
   logic [2:0] trig_reg = 3'h0;
   logic [2:0] trig_next;
   assign raw_compare_out = raw_lvl;
   assign filtered_compare_out = filt_lvl;
   always_comb begin
      trig_next = fire ? 3'h4 : trig_reg - {2'b00, trig_reg != 3'h0};
   end
   always_ff @(posedge aclk) begin
      trig_reg <= trig_next;
   end
   assign timer_trigger = trig_reg != 3'h0;
endmodule : cco_far_model

// ---- testbench/cco_control_tb.sv ----
// Testbench for the comparator control block
`timescale 1ns/100ps
`include "cco_map.svh"
module cco_control_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, cnt, cdac;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic raw_compare_out, filtered_compare_out, timer_trigger, pin_out, pin_oe;
   logic mux_same_input = 1'b0, pin_owned = 1'b0, raw_lvl = 1'b0, filt_lvl = 1'b0, fire = 1'b0;
   logic analog_power_on, dac_power_on, speed_power_sel, sample_mode_sel;
   logic module_compare_out, status_compare_out;
   logic [2:0] filter_count;
   int n_fail = 0, total_checks = 0;
   cco_control uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .raw_compare_out(raw_compare_out), .filtered_compare_out(filtered_compare_out),
      .timer_trigger(timer_trigger), .mux_same_input(mux_same_input), .pin_owned(pin_owned),
      .analog_power_on(analog_power_on), .dac_power_on(dac_power_on),
      .speed_power_sel(speed_power_sel), .sample_mode_sel(sample_mode_sel),
      .filter_count(filter_count), .module_compare_out(module_compare_out),
      .pin_out(pin_out), .pin_oe(pin_oe), .status_compare_out(status_compare_out));
   cco_far_model far (.aclk(aclk), .raw_lvl(raw_lvl), .filt_lvl(filt_lvl), .fire(fire),
      .raw_compare_out(raw_compare_out), .filtered_compare_out(filtered_compare_out),
      .timer_trigger(timer_trigger));
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st = 4'h1);
      logic aw, w, b;
      b = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 40 && !b; i++) begin
         @(negedge aclk);
         aw = s_axi_awready;
         w = s_axi_wready;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (!b) begin
         n_fail++;
         close_out();
      end
   endtask : wr
   task automatic rd_reg(input logic [3:0] a);
      logic ar, r;
      r = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 40 && !r; i++) begin
         @(negedge aclk);
         ar = s_axi_arready;
         r = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (!r) begin
         n_fail++;
         close_out();
      end
   endtask : rd_reg
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : idle
   task automatic t_regs;
      rd_reg(`CCO_CTRL_ADDR);
      chk("ctrl reset", 32'h0, rd);
      for (int k = 0; k < 6; k++) begin
         wr(`CCO_CTRL_ADDR, 8'h01 << k);
         chk("write resp", 32'h0, {30'h0, rs});
         rd_reg(`CCO_CTRL_ADDR);
         chk("ctrl readback", 32'h1 << k, rd);
         chk("speed sel", {31'h0, k == 4}, {31'h0, speed_power_sel});
         chk("sample sel", 32'h0, {31'h0, sample_mode_sel});
      end
      wr(`CCO_CTRL_ADDR, 8'h3F, 4'h0);
      rd_reg(`CCO_CTRL_ADDR);
      chk("masked write", 32'h20, rd);
      wr(4'hC, 8'h01);
      chk("unmapped write", 32'h2, {30'h0, rs});
      rd_reg(4'hC);
      chk("unmapped read", 32'h2, {30'h0, rs});
      $display("t_regs done");
   endtask : t_regs
   task automatic t_out;
      raw_lvl <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(`CCO_CTRL_ADDR, {4'h0, k[0], k[1], 2'b01});
         idle(8);
         chk("module out", {31'h0, k[1] ^ k[0]}, {31'h0, module_compare_out});
         chk("pin value", {31'h0, k[1] ^ k[0]}, {31'h0, pin_out});
         rd_reg(`CCO_STAT_ADDR);
         chk("status reg", {31'h0, k[1] ^ k[0]}, rd);
      end
      $display("t_out done");
   endtask : t_out
   task automatic t_off;
      wr(`CCO_CTRL_ADDR, 8'h08);
      idle(4);
      chk("off power", 32'h0, {31'h0, analog_power_on});
      chk("off status", 32'h1, {31'h0, status_compare_out});
      @(posedge aclk);
      mux_same_input <= 1'b1;
      wr(`CCO_CTRL_ADDR, 8'h09);
      idle(4);
      chk("mux power", 32'h0, {31'h0, analog_power_on});
      chk("mux status", 32'h1, {31'h0, status_compare_out});
      mux_same_input <= 1'b0;
      idle(4);
      chk("on power", 32'h1, {31'h0, analog_power_on});
      $display("t_off done");
   endtask : t_off
   task automatic t_pin;
      for (int k = 0; k < 4; k++) begin
         @(posedge aclk);
         pin_owned <= k[1];
         wr(`CCO_CTRL_ADDR, {6'h00, k[0], 1'b1});
         idle(2);
         chk("pin enable", {31'h0, k[1] & k[0]}, {31'h0, pin_oe});
      end
      $display("t_pin done");
   endtask : t_pin
   task automatic t_trig;
      cnt = 32'h0;
      cdac = 32'h0;
      wr(`CCO_CTRL_ADDR, 8'h21);
      idle(6);
      chk("standby", 32'h0, {31'h0, analog_power_on});
      @(posedge aclk);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (14) begin
         @(negedge aclk);
         cnt = cnt + {31'h0, analog_power_on};
         cdac = cdac + {31'h0, dac_power_on};
      end
      chk("compares", 32'h1, cnt);
      chk("dac runs", 32'h1, cdac);
      $display("t_trig done");
   endtask : t_trig
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_out();
      t_off();
      t_pin();
      t_trig();
      close_out();
   end
endmodule : cco_control_tb
